//--- src/fci_pkg.sv
// Constants, types and command codes for the flash command host controller.
// Assumes a byte-wide flash with asynchronous strobes, driven from a 100 MHz aclk.
//
// Notes on behaviour
// R01 - Command bytes: 20 erase, 40 program, 50 clear, 70 status, 90 id, B0, D0, FF.
// R02 - Host never sends 00 or any unassigned command code.
// R03 - Boot region writes need high voltage on supply and reset/power-down pins.
// R04 - Missing voltage aborts write and sets supply-low, program or erase error.
// R05 - While programming only status reads; while erasing also erase suspend.
// R06 - Finished automaton sets ready bit; front end stays in status-read mode.
// R07 - Identifier mode: maker code at address 0, part code at address 1.
// R08 - Read right after a started program or erase returns status contents.
// R09 - Two read-array commands abort and return to array read mode.
// R10 - Bad command after erase setup sets both error bits, status mode.
// R11 - After read-status every read returns status whatever the address.
// R12 - Clear-status resets error bits; automaton never clears them.
// R13 - Program setup arms the next write to load address and data.
// R14 - Write after program setup starts programming; host needs read-array afterwards.
// R15 - Erase confirm starts erase; only status and suspend accepted meanwhile.
// R16 - Confirm without setup is ignored and sets both error bits.
// R17 - Status refreshes only when output enable or chip select toggles.
// R18 - Suspend only acts during erase; meanwhile only status and resume accepted.
// R19 - Suspended: ready and suspend bits set; array, status, resume accepted.
// R20 - Supply loss while suspended aborts erase; reset/power-down stops all.
// R21 - During suspend host reads only blocks other than the one erased.
// R22 - Resume clears suspend and ready bit only if suspend was issued.
// R23 - After reset/power-down release the device starts in array read mode.
// R24 - Command is captured on whichever strobe deasserts first.

package fci_pkg;

	// ----------------------------------------------------------------
	// Flash command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
	localparam logic [7:0] CMD_PROG_SETUP   = 8'h40;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
	localparam logic [7:0] CMD_IDENT        = 8'h90;
	localparam logic [7:0] CMD_SUSPEND      = 8'hB0;
	localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
	localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;

	// ----------------------------------------------------------------
	// Status register bit positions of the flash
	// ----------------------------------------------------------------
	localparam int SR_READY_BIT   = 7;
	localparam int SR_SUSPEND_BIT = 6;
	localparam int SR_ERASE_BIT   = 5;
	localparam int SR_PROG_BIT    = 4;
	localparam int SR_SUPPLY_BIT  = 3;

	// ----------------------------------------------------------------
	// Controller register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_WDATA  = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_RDATA  = 8'h10;
	localparam logic [7:0] REG_PINS   = 8'h14;

	// Control register fields
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_GO_BIT = 8;

	// Pin control register fields
	localparam int PINS_RESET_BIT = 0;
	localparam int PINS_VPP_BIT   = 1;
	localparam int PINS_HV_BIT    = 2;

	// ----------------------------------------------------------------
	// Bus timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS    = 10;
	localparam int STROBE_NS        = 100;
	localparam int STROBE_CYCLES    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOVERY_NS      = 40;
	localparam int RECOVERY_CYCLES  = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [31:0] PINS_RESET_VALUE = 32'h0000_0001;

	// Operations ordered from software
	typedef enum logic [1:0] {
		FCI_OP_WRITE = 2'h0,
		FCI_OP_READ  = 2'h1
	} fci_op_type;

	// Flash-side pin bundle
	typedef struct packed {
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic        dq_oe;
		logic [7:0]  dq_out;
		logic [17:0] addr;
	} fci_pins_type;

	// Sequencer states, Gray from idle to gap; gap back to idle flips two bits
	typedef enum logic [2:0] {
		FCI_IDLE   = 3'b000,
		FCI_SETUP  = 3'b001,
		FCI_STROBE = 3'b011,
		FCI_HOLD   = 3'b010,
		FCI_GAP    = 3'b110
	} fci_state_type;

endpackage

//--- src/fci_cycle.sv
// Bus cycle sequencer: one flash write or read cycle per request.
// Assumes flash pins are synchronous to aclk; strobes are generated here.
`default_nettype none

module fci_cycle #(
	parameter int STROBE = fci_pkg::STROBE_CYCLES,
	parameter int GAP    = fci_pkg::RECOVERY_CYCLES
) (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic                start,
	input  wire logic                is_read,
	input  wire logic [17:0]         addr,
	input  wire logic [7:0]          wdata,
	input  wire logic [7:0]          dq_in,
	output logic                     busy,
	output logic                     done,
	output logic [7:0]               rdata,
	output fci_pkg::fci_pins_type    pins
);

	// Refuse timing counts that the 8-bit counter cannot hold
	if (STROBE < 1 || STROBE > 255 || GAP < 1 || GAP > 255) begin
		$error("fci_cycle: timing counts out of range");
	end

	fci_pkg::fci_state_type state;
	logic [7:0]             count;
	logic                   rd;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// Each request drives one strobe low then high, so chip select toggles
	// between polls and the flash latches fresh status on every read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= fci_pkg::FCI_IDLE;
			count <= 8'h00;
			rd    <= 1'b0;
			pins  <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe: 1'b0,
				dq_out: 8'h00, addr: 18'h00000};
			rdata <= 8'h00;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state)
				fci_pkg::FCI_IDLE: begin
					if (start) begin
						rd          <= is_read;
						pins.addr   <= addr;
						pins.dq_out <= wdata;
						pins.dq_oe  <= !is_read;
						state       <= fci_pkg::FCI_SETUP;
					end
				end
				fci_pkg::FCI_SETUP: begin
					pins.ce_n <= 1'b0;
					pins.oe_n <= !rd;
					pins.we_n <= rd;
					count     <= 8'(STROBE);
					state     <= fci_pkg::FCI_STROBE;
				end
				fci_pkg::FCI_STROBE: begin
					if (count == 8'h01) begin
						// Write strobe rises before chip select, taking the command [R24]
						pins.we_n <= 1'b1;
						pins.oe_n <= 1'b1;
						if (rd) begin
							rdata <= dq_in;
						end
						state <= fci_pkg::FCI_HOLD;
					end else begin
						count <= count - 8'h01;
					end
				end
				fci_pkg::FCI_HOLD: begin
					pins.ce_n  <= 1'b1; // Toggled once per cycle [R17]
					pins.dq_oe <= 1'b0;
					count      <= 8'(GAP);
					state      <= fci_pkg::FCI_GAP;
				end
				fci_pkg::FCI_GAP: begin
					if (count == 8'h01) begin
						done  <= 1'b1;
						state <= fci_pkg::FCI_IDLE;
					end else begin
						count <= count - 8'h01;
					end
				end
				default: begin
					state <= fci_pkg::FCI_IDLE;
				end
			endcase
		end
	end

	assign busy = (state != fci_pkg::FCI_IDLE);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_we_under_ce: assert property (@(posedge aclk) disable iff (!aresetn)
		!pins.we_n |-> !pins.ce_n) // [R24]
		else $error("write strobe low without chip select");
	a_ce_toggles: assert property (@(posedge aclk) disable iff (!aresetn)
		done |-> $past(pins.ce_n, 1) && pins.ce_n) // [R17]
		else $error("chip select not released before completion");
	a_we_rises_first: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(pins.we_n) |-> !pins.ce_n) // [R24]
		else $error("chip select rose with or before write strobe");
	c_write_cycle: cover property (@(posedge aclk) disable iff (!aresetn)
		$rose(pins.we_n));
	c_read_cycle: cover property (@(posedge aclk) disable iff (!aresetn)
		$rose(pins.oe_n));

endmodule

`default_nettype wire

//--- src/fci_host.sv
// Host controller for a byte-wide boot-block flash: AXI4-Lite slave in,
// flash command cycles out. Software composes command sequences; the
// controller runs single bus cycles and tracks the flash's read mode.
// Assumes flash pins synchronous to aclk and one bus master.
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`default_nettype none

module fci_host (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	output logic                     flash_ce_n,
	output logic                     flash_oe_n,
	output logic                     flash_we_n,
	output logic [17:0]              flash_addr,
	output logic [7:0]               flash_dq_out,
	output logic                     flash_dq_oe,
	input  wire logic [7:0]          flash_dq_in,
	output logic                     reset_powerdown_n,
	output logic                     program_supply_on,
	output logic                     high_program_voltage
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		FCI_MODE_ARRAY   = 3'h0,
		FCI_MODE_STATUS  = 3'h1,
		FCI_MODE_IDENT   = 3'h2,
		FCI_MODE_PSETUP  = 3'h3,
		FCI_MODE_ESETUP  = 3'h4
	} fci_mode_type;

	logic [17:0]           addr_reg;
	logic [7:0]            wdata_reg;
	logic                  op_read;
	logic                  go;
	logic                  busy;
	logic                  done;
	logic [7:0]            rdata;
	logic [2:0]            pin_ctrl;
	logic [7:0]            status_seen;
	logic                  last_was_ff;
	logic                  refused;
	logic                  error_seen;
	fci_mode_type          mode;
	fci_pkg::fci_pins_type pins;
	logic                  aw_hold;
	logic                  w_hold;
	logic [7:0]            aw_addr;
	logic [31:0]           w_data;
	logic                  wr_fire;
	logic                  ctrl_write;

	// True for command codes the flash assigns; others are never sent [R02]
	function automatic logic fci_valid_cmd(input logic [7:0] c);
		fci_valid_cmd = (c == fci_pkg::CMD_ERASE_SETUP) || (c == fci_pkg::CMD_PROG_SETUP)
			|| (c == fci_pkg::CMD_CLEAR_STATUS) || (c == fci_pkg::CMD_READ_STATUS)
			|| (c == fci_pkg::CMD_IDENT) || (c == fci_pkg::CMD_SUSPEND)
			|| (c == fci_pkg::CMD_CONFIRM) || (c == fci_pkg::CMD_READ_ARRAY);
	endfunction

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	assign s_axi_awready = !aw_hold && !s_axi_bvalid;
	assign s_axi_wready  = !w_hold && !s_axi_bvalid;
	assign wr_fire       = aw_hold && w_hold && !s_axi_bvalid;
	assign s_axi_bresp   = 2'h0;
	assign ctrl_write    = wr_fire && (aw_addr == fci_pkg::REG_CTRL);

	// Collect address and data in either order, answer once both held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold      <= 1'b0;
			w_hold       <= 1'b0;
			aw_addr      <= 8'h00;
			w_data       <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata;
			end
			if (wr_fire) begin
				aw_hold      <= 1'b0;
				w_hold       <= 1'b0;
				s_axi_bvalid <= 1'b1;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Software registers; a go while busy or with a bad code is refused
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			addr_reg  <= 18'h00000;
			wdata_reg <= 8'h00;
			op_read   <= 1'b0;
			go        <= 1'b0;
			refused   <= 1'b0;
			pin_ctrl  <= fci_pkg::PINS_RESET_VALUE[2:0];
		end else begin
			go <= 1'b0;
			if (wr_fire && aw_addr == fci_pkg::REG_ADDR) begin
				addr_reg <= w_data[17:0];
			end
			if (wr_fire && aw_addr == fci_pkg::REG_WDATA) begin
				wdata_reg <= w_data[7:0];
			end
			if (wr_fire && aw_addr == fci_pkg::REG_PINS) begin
				pin_ctrl <= w_data[2:0];
			end
			if (ctrl_write && w_data[fci_pkg::CTRL_GO_BIT]) begin
				op_read <= (w_data[1:0] == fci_pkg::FCI_OP_READ);
				if (busy || (w_data[1:0] != fci_pkg::FCI_OP_READ
					&& mode != FCI_MODE_PSETUP && !fci_valid_cmd(wdata_reg))) begin
					refused <= 1'b1; // [R02]
				end else begin
					go <= 1'b1;
				end
			end else if (ctrl_write) begin
				refused <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Flash pins
	// ----------------------------------------------------------------
	// Boot region writes need both pins raised; software sets them here [R03]
	assign reset_powerdown_n    = pin_ctrl[fci_pkg::PINS_RESET_BIT];
	assign program_supply_on    = pin_ctrl[fci_pkg::PINS_VPP_BIT];
	assign high_program_voltage = pin_ctrl[fci_pkg::PINS_HV_BIT];
	assign flash_ce_n   = pins.ce_n;
	assign flash_oe_n   = pins.oe_n;
	assign flash_we_n   = pins.we_n;
	assign flash_addr   = pins.addr;
	assign flash_dq_out = pins.dq_out;
	assign flash_dq_oe  = pins.dq_oe;

	fci_cycle u_cycle (
		.aclk    (aclk),
		.aresetn (aresetn),
		.start   (go),
		.is_read (op_read),
		.addr    (addr_reg),
		.wdata   (wdata_reg),
		.dq_in   (flash_dq_in),
		.busy    (busy),
		.done    (done),
		.rdata   (rdata),
		.pins    (pins)
	);

	// ----------------------------------------------------------------
	// Read mode tracking of the flash
	// ----------------------------------------------------------------
	// Mirrors which source the flash read path points at, so software knows
	// whether a read returns array, status or identifier data
	always_ff @(posedge aclk) begin
		if (!aresetn || !reset_powerdown_n) begin
			mode        <= FCI_MODE_ARRAY; // [R23] [R20]
			last_was_ff <= 1'b0;
		end else if (go && !op_read) begin
			last_was_ff <= (wdata_reg == fci_pkg::CMD_READ_ARRAY) && mode != FCI_MODE_PSETUP;
			case (mode)
				FCI_MODE_PSETUP: begin
					// Second write latches target and payload, then status [R13] [R14] [R08]
					mode <= FCI_MODE_STATUS;
				end
				FCI_MODE_ESETUP: begin
					// Either way the flash shows status next [R10] [R15]
					mode <= FCI_MODE_STATUS;
				end
				default: begin
					case (wdata_reg)
						fci_pkg::CMD_READ_ARRAY: begin
							// Second read-array in a row reaches the array [R09]
							mode <= (mode == FCI_MODE_STATUS && !last_was_ff && error_seen)
								? FCI_MODE_STATUS : FCI_MODE_ARRAY;
						end
						fci_pkg::CMD_READ_STATUS:  mode <= FCI_MODE_STATUS; // [R11]
						fci_pkg::CMD_IDENT:        mode <= FCI_MODE_IDENT;  // [R07]
						fci_pkg::CMD_PROG_SETUP:   mode <= FCI_MODE_PSETUP; // [R13]
						fci_pkg::CMD_ERASE_SETUP:  mode <= FCI_MODE_ESETUP; // [R01]
						fci_pkg::CMD_CONFIRM:      mode <= FCI_MODE_STATUS; // [R16] [R22]
						fci_pkg::CMD_SUSPEND:      mode <= mode; // No source change [R18] [R21]
						default:                   mode <= mode;
					endcase
				end
			endcase
		end
	end

	// Keeps the last status byte read; error flag follows it, set only when erase and program bits are both set [R12]
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_seen <= 8'h00;
			error_seen  <= 1'b0;
		end else if (done && op_read && mode == FCI_MODE_STATUS) begin
			status_seen <= rdata; // [R06] [R19] [R04]
			error_seen  <= rdata[fci_pkg::SR_ERASE_BIT] && rdata[fci_pkg::SR_PROG_BIT];
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	assign s_axi_arready = !s_axi_rvalid;
	assign s_axi_rresp   = 2'h0;

	// Register read mux; unmapped offsets read zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			case (s_axi_araddr)
				fci_pkg::REG_CTRL:   s_axi_rdata <= {23'h000000, go, 7'h00, op_read};
				fci_pkg::REG_ADDR:   s_axi_rdata <= {14'h0000, addr_reg};
				fci_pkg::REG_WDATA:  s_axi_rdata <= {24'h000000, wdata_reg};
				fci_pkg::REG_STATUS: s_axi_rdata <= {16'h0000, status_seen, 2'h0,
					refused, mode, done, busy};
				fci_pkg::REG_RDATA:  s_axi_rdata <= {24'h000000, rdata};
				fci_pkg::REG_PINS:   s_axi_rdata <= {29'h00000000, pin_ctrl};
				default:             s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_psetup_status: assert property (@(posedge aclk) disable iff (!aresetn)
		(go && !op_read && mode == FCI_MODE_PSETUP && reset_powerdown_n)
		|=> mode == FCI_MODE_STATUS) // [R14]
		else $error("program write did not enter status mode");
	a_ident_mode: assert property (@(posedge aclk) disable iff (!aresetn)
		(go && !op_read && mode == FCI_MODE_ARRAY && wdata_reg == fci_pkg::CMD_IDENT
		&& reset_powerdown_n) |=> mode == FCI_MODE_IDENT) // [R07]
		else $error("identifier command not tracked");
	a_no_bad_code: assert property (@(posedge aclk) disable iff (!aresetn)
		(go && !op_read && mode != FCI_MODE_PSETUP) |-> fci_valid_cmd(wdata_reg)) // [R02]
		else $error("unassigned command code sent");
	a_go_idle: assert property (@(posedge aclk) disable iff (!aresetn)
		go |-> ##1 busy ##[1:600] done) // [R24]
		else $error("bus cycle did not complete");
	a_esetup_status: assert property (@(posedge aclk) disable iff (!aresetn)
		(go && !op_read && mode == FCI_MODE_ESETUP && reset_powerdown_n)
		|=> mode == FCI_MODE_STATUS) // [R10]
		else $error("command after erase setup did not enter status");
	a_reset_array: assert property (@(posedge aclk) disable iff (!aresetn)
		!reset_powerdown_n |=> mode == FCI_MODE_ARRAY) // [R23]
		else $error("power-down did not restore array mode");
	a_status_mode: assert property (@(posedge aclk) disable iff (!aresetn)
		(go && !op_read && mode != FCI_MODE_PSETUP && mode != FCI_MODE_ESETUP
		&& wdata_reg == fci_pkg::CMD_READ_STATUS && reset_powerdown_n)
		|=> mode == FCI_MODE_STATUS) // [R11]
		else $error("read-status not tracked");
	a_bresp_once: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire |=> s_axi_bvalid)
		else $error("write response missing");
	c_program_seq: cover property (@(posedge aclk) disable iff (!aresetn)
		mode == FCI_MODE_PSETUP ##[1:200] mode == FCI_MODE_STATUS);
	c_erase_seq: cover property (@(posedge aclk) disable iff (!aresetn)
		mode == FCI_MODE_ESETUP ##[1:200] mode == FCI_MODE_STATUS);
	c_refused: cover property (@(posedge aclk) disable iff (!aresetn) $rose(refused));

endmodule

`default_nettype wire

//--- test/fci_flash_model.sv
// Flash device model: command decode, status byte, identifier codes, tiny array.
// Assumes strobes from the host controller; the data bus is split into in and out.
`default_nettype none

module fci_flash_model #(
	parameter logic [7:0] MAKER = 8'hA5, // Arbitrary value
	parameter logic [7:0] PART  = 8'h3C  // Arbitrary value
) (
	input  wire logic        aclk,
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic [17:0] addr,
	input  wire logic [7:0]  dq,
	output logic [7:0]       dq_in,
	input  wire logic        rp_n,
	input  wire logic        vpp,
	input  wire logic        hv
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] mode;
	logic [7:0] sr;
	logic [7:0] last;
	logic [7:0] rd;
	logic [7:0] mem [4];
	logic       ps;
	logic       es;
	logic       ok;
	// Power-up state, array mode with the automaton ready
	initial begin
		{mode, ps, es, last} = 12'h0;
		sr = 8'h80;
		for (int i = 0; i < 4; i++) mem[i] = 8'hFF;
	end
	// Boot region writes need both high voltages
	assign ok = vpp && (!addr[17] || hv);
	// Command decode on the rising write strobe; writes finish at once
	always @(posedge we_n or negedge rp_n) begin
		if (!rp_n) begin
			{mode, ps, es} = 4'h0;
			sr <= 8'h80;
		end else if (!ce_n) begin
			if (ps) begin
				ps <= 1'b0;
				if (ok) mem[addr[1:0]] <= mem[addr[1:0]] & dq;
				else sr <= sr | 8'h18;
			end else if (es) begin
				es <= 1'b0;
				if (dq != 8'hD0) sr <= sr | 8'h30;
				else if (!ok) sr <= sr | 8'h28;
			end else begin
				case (dq)
					8'h20: {es, mode} <= 3'h5;
					8'h40: {ps, mode} <= 3'h5;
					8'h50: sr <= sr & 8'hC7;
					8'h70: mode <= 2'h1;
					8'h90: mode <= 2'h2;
					8'hB0: ; // Nothing to suspend, writes finish at once
					8'hD0: sr <= sr | 8'h30;
					8'hFF: mode <= 2'h0;
					default: ;
				endcase
			end
		end
	end
	// Read path steered by the mode
	always_comb begin
		case (mode)
			2'h1: rd = sr;
			2'h2: rd = addr[0] ? PART : MAKER;
			default: rd = mem[addr[1:0]];
		endcase
	end
	// A released bus shows the inverse of the last byte
	always @(posedge aclk) if (!ce_n && !oe_n) last <= rd;
	assign dq_in = (!ce_n && !oe_n) ? rd : ~last;
endmodule

`default_nettype wire

//--- test/test_flash_command_interface.sv
// Testbench for the flash host controller: register tasks over AXI4-Lite.
// Assumes the flash model above on the far side of the flash pins.
`default_nettype none

module test_flash_command_interface;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] MK = 8'hA5; // Arbitrary value
	localparam logic [7:0] PT = 8'h3C; // Arbitrary value
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, flash_ce_n, flash_oe_n;
	logic        flash_we_n, reset_powerdown_n, program_supply_on, high_program_voltage;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, flash_dq_out, flash_dq_in;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0]  s_axi_wstrb;
	logic [17:0] flash_addr;
	logic        flash_dq_oe;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	int          err_count, compares;

	fci_host i_fci_host (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .flash_ce_n,
		.flash_oe_n, .flash_we_n, .flash_addr, .flash_dq_out, .flash_dq_oe,
		.flash_dq_in, .reset_powerdown_n, .program_supply_on, .high_program_voltage);
	fci_flash_model #(.MAKER(MK), .PART(PT)) i_fci_flash_model (.aclk, .ce_n(flash_ce_n),
		.oe_n(flash_oe_n), .we_n(flash_we_n), .addr(flash_addr),
		.dq(flash_dq_oe ? flash_dq_out : ~flash_dq_out), // Undriven bus reads inverted
		.dq_in(flash_dq_in), .rp_n(reset_powerdown_n), .vpp(program_supply_on),
		.hv(high_program_voltage));

	// ----------------------------------------------------------------
	// Bus tasks and comparison
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Register write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic da, dw, db;
		{da, dw, db} = 3'h0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (n = 0; n < 100 && !(da && dw && db); n++) begin
			@(negedge aclk);
			da |= s_axi_awvalid && s_axi_awready;
			dw |= s_axi_wvalid && s_axi_wready;
			if (s_axi_bvalid && s_axi_bready) check({30'h0, s_axi_bresp}, 32'h0);
			db |= s_axi_bvalid && s_axi_bready;
			@(posedge aclk);
			if (da) s_axi_awvalid <= 1'b0;
			if (dw) s_axi_wvalid <= 1'b0;
			if (db) s_axi_bready <= 1'b0;
		end
		if (n == 100) begin
			err_count++;
			complete_run();
		end
		@(posedge aclk); // Idle edge, so the next request never re-drives in this step
	endtask
	// Register read, data taken on the falling edge before the handshake edge
	task automatic rd(input logic [7:0] a);
		int n;
		logic da, db;
		{da, db} = 2'h0;
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		for (n = 0; n < 100 && !(da && db); n++) begin
			@(negedge aclk);
			da |= s_axi_arvalid && s_axi_arready;
			if (s_axi_rvalid && s_axi_rready) rv = s_axi_rdata;
			if (s_axi_rvalid && s_axi_rready) check({30'h0, s_axi_rresp}, 32'h0);
			db |= s_axi_rvalid && s_axi_rready;
			@(posedge aclk);
			if (da) s_axi_arvalid <= 1'b0;
			if (db) s_axi_rready <= 1'b0;
		end
		if (n == 100) begin
			err_count++;
			complete_run();
		end
		@(posedge aclk); // Idle edge, so the next request never re-drives in this step
	endtask
	// One flash bus cycle, then wait until the sequencer is idle
	task automatic op(input logic r, input logic [17:0] a, input logic [7:0] d);
		int n;
		wr(fci_pkg::REG_ADDR, {14'h0, a});
		wr(fci_pkg::REG_WDATA, {24'h0, d});
		wr(fci_pkg::REG_CTRL, {23'h0, 1'b1, 7'h0, r});
		rv = 32'h1;
		for (n = 0; n < 100 && rv[0]; n++) rd(fci_pkg::REG_STATUS);
		if (n == 100) begin
			err_count++;
			complete_run();
		end
		if (r) rd(fci_pkg::REG_RDATA);
	endtask
	task automatic fr(input logic [17:0] a, input logic [7:0] e);
		op(1'b1, a, 8'h0);
		check(rv, {24'h0, e});
	endtask
	task automatic md(input logic [2:0] m);
		rd(fci_pkg::REG_STATUS);
		check({29'h0, rv[4:2]}, {29'h0, m});
	endtask

	// Free-running clock
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// Main sequence
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h0;
		{s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 49'h0;
		{err_count, compares, s_axi_wstrb} = 68'hF;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(fci_pkg::REG_PINS);
		check(rv, fci_pkg::PINS_RESET_VALUE);
		md(3'h0);
		fr(18'h0, 8'hFF);
		op(1'b0, 18'h0, 8'h90);
		fr(18'h2, MK);
		fr(18'h3FFFF, PT);
		wr(fci_pkg::REG_PINS, 32'h0);
		wr(fci_pkg::REG_PINS, 32'h1);
		md(3'h0);
		op(1'b0, 18'h0, 8'h70);
		fr(18'h15, 8'h80);
		op(1'b0, 18'h0, 8'h40);
		md(3'h3);
		op(1'b0, 18'h1, 8'h12);
		fr(18'h1, 8'h98);
		op(1'b0, 18'h0, 8'h50);
		fr(18'h0, 8'h80);
		wr(fci_pkg::REG_PINS, 32'h7);
		check({31'h0, program_supply_on & high_program_voltage}, 32'h1);
		op(1'b0, 18'h0, 8'h40);
		op(1'b0, 18'h1, 8'h5A);
		fr(18'h1, 8'h80);
		op(1'b0, 18'h0, 8'hFF);
		fr(18'h1, 8'h5A);
		op(1'b0, 18'h0, 8'h40);
		op(1'b0, 18'h0, 8'hFF);
		fr(18'h0, 8'h80);
		op(1'b0, 18'h0, 8'hFF);
		fr(18'h0, 8'hFF);
		op(1'b0, 18'h0, 8'hD0);
		op(1'b0, 18'h0, 8'h70);
		fr(18'h0, 8'hB0);
		op(1'b0, 18'h0, 8'h50);
		op(1'b0, 18'h0, 8'h20);
		op(1'b0, 18'h0, 8'hFF);
		fr(18'h0, 8'hB0);
		op(1'b0, 18'h0, 8'hFF);
		fr(18'h1, 8'h5A);
		op(1'b0, 18'h0, 8'hB0);
		md(3'h0);
		fr(18'h1, 8'h5A);
		op(1'b0, 18'h0, 8'h00);
		check({31'h0, rv[5]}, 32'h1);
		wr(fci_pkg::REG_CTRL, 32'h0);
		rd(fci_pkg::REG_STATUS);
		check({31'h0, rv[5]}, 32'h0);
		rd(8'h1C);
		check(rv, 32'h0);
		complete_run();
	end
endmodule

`default_nettype wire
